// ===== core/msp_mode_select.v
// Purpose: Mode select interpreter with APB register access
// Assumes: Software loads the command block and data, then starts
// Notes: Saved copy stands in for nonvolatile storage
`timescale 1ns/1ns
`default_nettype none
`include "msp_regs.vh"
module msp_mode_select
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr
);
  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;

  reg state;
  reg [7:0] cdb [0:5];
  reg [2:0] cmd_id;
  reg [7:0] buf_mem [0:31];
  reg [5:0] buf_cnt;
  reg [7:0] work_mem [0:27];
  reg [7:0] save_mem [0:27];
  reg [7:0] attn;
  reg [2:0] req_id;
  reg req_check;
  reg st_done;
  reg st_check;
  reg [3:0] st_key;
  reg [7:0] st_asc;
  reg [7:0] st_ascq;
  reg [31:0] next_prdata;
  reg next_err;
  integer i;

  wire op_ok;
  wire pf_ok;
  wire len_ok;
  wire len_zero;
  wire save_req;
  wire has_addr;
  wire [1:0] n_small;

  wire setup = psel && !penable;
  wire wr_fire = psel && penable && pready && pwrite;
  wire wr_ctrl = wr_fire && (paddr == `MSP_ADDR_CTRL);
  wire wr_data = wr_fire && (paddr == `MSP_ADDR_DATA);
  wire wr_req = wr_fire && (paddr == `MSP_ADDR_REQ);
  wire start = wr_ctrl && pwdata[`MSP_CTRL_START] && (state == ST_IDLE);
  wire reload = wr_ctrl && (pwdata[`MSP_CTRL_BUS_RESET] || pwdata[`MSP_CTRL_DEV_RESET]);

  msp_cdb_check u_cdb
  (
    .cdb_op(cdb[0]),
    .cdb_flags(cdb[1]),
    .cdb_len(cdb[4]),
    .op_ok(op_ok),
    .pf_ok(pf_ok),
    .len_ok(len_ok),
    .len_zero(len_zero),
    .save_req(save_req),
    .has_addr(has_addr),
    .n_small(n_small)
  );

  // Small pages follow the address page when it is present
  wire [4:0] pos0 = has_addr ? 5'd24 : 5'd4; // [R9]
  wire [4:0] pos1 = pos0 + 5'd4;
  wire [5:0] code0 = buf_mem[pos0][5:0];
  wire [5:0] code1 = buf_mem[pos1][5:0];
  wire plen0_ok = (buf_mem[pos0 + 5'd1] == `MSP_SMALL_PAGE_PLEN);
  wire plen1_ok = (buf_mem[pos1 + 5'd1] == `MSP_SMALL_PAGE_PLEN);
  wire c0_par = (code0 == `MSP_PAR_PAGE_CODE);
  wire c0_baud = (code0 == `MSP_BAUD_PAGE_CODE);
  wire c1_par = (code1 == `MSP_PAR_PAGE_CODE);
  wire c1_baud = (code1 == `MSP_BAUD_PAGE_CODE);

  wire hdr_ok = (buf_mem[0] == 8'h00) && (buf_mem[1] == 8'h00) &&
                (buf_mem[2] == 8'h00) && (buf_mem[3] == 8'h00); // [R14]
  wire addr_ok = !has_addr ||
                 ((buf_mem[4][5:0] == `MSP_ADDR_PAGE_CODE) && (buf_mem[5] == `MSP_ADDR_PAGE_PLEN) &&
                  ({buf_mem[8], buf_mem[9]} == `MSP_NUM_MT) &&
                  ({buf_mem[12], buf_mem[13]} == `MSP_NUM_STORAGE) &&
                  ({buf_mem[14], buf_mem[15]} == `MSP_FIRST_IE) &&
                  ({buf_mem[16], buf_mem[17]} == `MSP_NUM_IE) &&
                  ({buf_mem[20], buf_mem[21]} == `MSP_NUM_DT)); // [R8]
  reg small_ok;
  always @*
  begin
    case (n_small)
      2'd0: small_ok = 1'b1;
      2'd1: small_ok = (c0_par || c0_baud) && plen0_ok;
      2'd2: small_ok = ((c0_par && c1_baud) || (c0_baud && c1_par)) && plen0_ok && plen1_ok;
      default: small_ok = 1'b0;
    endcase
  end
  wire cnt_ok = ({2'b00, buf_cnt} == cdb[4]);
  wire data_ok = hdr_ok && addr_ok && small_ok; // [R12]

  wire has_par = (n_small != 2'd0) && (c0_par || (n_small == 2'd2));
  wire has_baud = (n_small != 2'd0) && (c0_baud || (n_small == 2'd2));
  wire [4:0] par_pos = c0_par ? pos0 : pos1;
  wire [4:0] baud_pos = c0_baud ? pos0 : pos1;

  // Full verdict of the command, evaluated on the execute cycle
  wire cmd_good = op_ok && pf_ok && len_ok && (len_zero || (cnt_ok && data_ok));
  wire commit = (state == ST_EXEC) && cmd_good && !len_zero; // [R12]

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE: state <= start ? ST_EXEC : ST_IDLE;
        ST_EXEC: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Command result and sense data
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_done <= 1'b0;
      st_check <= 1'b0;
      st_key <= `MSP_KEY_GOOD;
      st_asc <= `MSP_ASC_NONE;
      st_ascq <= `MSP_ASCQ_NONE;
    end
    else if (start)
      st_done <= 1'b0;
    else if (state == ST_EXEC)
    begin
      st_done <= 1'b1;
      st_check <= !cmd_good;
      st_ascq <= `MSP_ASCQ_NONE;
      if (!op_ok)
      begin
        st_key <= `MSP_KEY_ILLEGAL;
        st_asc <= `MSP_ASC_BAD_OPCODE;
      end
      else if (!pf_ok || !len_ok)
      begin
        st_key <= `MSP_KEY_ILLEGAL; // [R15]
        st_asc <= `MSP_ASC_CDB_FIELD;
      end
      else if (len_zero)
      begin
        st_key <= `MSP_KEY_GOOD; // [R7]
        st_asc <= `MSP_ASC_NONE;
      end
      else if (!cnt_ok)
      begin
        st_key <= `MSP_KEY_ILLEGAL;
        st_asc <= `MSP_ASC_LIST_LEN;
      end
      else if (!data_ok)
      begin
        st_key <= `MSP_KEY_ILLEGAL; // [R12]
        st_asc <= `MSP_ASC_PARAM_FIELD;
      end
      else
      begin
        st_key <= `MSP_KEY_GOOD;
        st_asc <= `MSP_ASC_NONE;
      end
    end
  end

  // Command block, issuer and parameter buffer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < 6; i = i + 1)
        cdb[i] <= 8'h00;
      cmd_id <= 3'h0;
      buf_cnt <= 6'h00;
    end
    else
    begin
      if (wr_fire && (paddr == `MSP_ADDR_CMD0) && (state == ST_IDLE))
      begin
        cdb[0] <= pwdata[7:0];
        cdb[1] <= pwdata[15:8];
        cdb[2] <= pwdata[23:16];
        cdb[3] <= pwdata[31:24];
      end
      if (wr_fire && (paddr == `MSP_ADDR_CMD1) && (state == ST_IDLE))
      begin
        cdb[4] <= pwdata[7:0];
        cdb[5] <= pwdata[15:8];
        cmd_id <= pwdata[18:16];
      end
      if ((state == ST_EXEC) || (wr_ctrl && pwdata[`MSP_CTRL_FLUSH]))
        buf_cnt <= 6'h00;
      else if (wr_data && (state == ST_IDLE) && (buf_cnt != 6'd`MSP_BUF_DEPTH))
        buf_cnt <= buf_cnt + 6'h01;
    end
  end

  always @(posedge pclk)
  begin
    if (wr_data && (state == ST_IDLE) && (buf_cnt != 6'd`MSP_BUF_DEPTH))
      buf_mem[buf_cnt[4:0]] <= pwdata[7:0];
  end

  // Reset defaults, byte 0 in the top bits
  localparam [223:0] DFLT_ALL = {{2'b00, `MSP_ADDR_PAGE_CODE}, `MSP_ADDR_PAGE_PLEN,
    `MSP_DFLT_MT_ADDR, `MSP_NUM_MT, `MSP_DFLT_ST_ADDR, `MSP_NUM_STORAGE, `MSP_FIRST_IE, `MSP_NUM_IE,
    `MSP_DFLT_DT_ADDR, `MSP_NUM_DT, 16'h0000, {2'b00, `MSP_PAR_PAGE_CODE}, `MSP_SMALL_PAGE_PLEN,
    `MSP_DFLT_SMALL_VAL, {2'b00, `MSP_BAUD_PAGE_CODE}, `MSP_SMALL_PAGE_PLEN, `MSP_DFLT_SMALL_VAL};

  // Shared working and saved configuration, one entry per byte
  genvar g;
  generate
    for (g = 0; g < `MSP_CFG_BYTES; g = g + 1)
    begin : g_cfg
      localparam [7:0] DFLT = DFLT_ALL[223 - 8 * g -: 8];
      wire take;
      wire [7:0] src;
      if (g < 20)
      begin : g_addr
        assign take = has_addr;
        assign src = buf_mem[g + 4];
      end
      else if (g < 24)
      begin : g_par
        assign take = has_par;
        assign src = buf_mem[par_pos + g - 20];
      end
      else
      begin : g_baud
        assign take = has_baud;
        assign src = buf_mem[baud_pos + g - 24];
      end
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          work_mem[g] <= DFLT; // [R13]
        else if (commit && take)
          work_mem[g] <= src; // [R4] [R10]
        else if (reload)
          work_mem[g] <= save_mem[g]; // [R13]
      end
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          save_mem[g] <= DFLT;
        else if (commit && take && save_req)
          save_mem[g] <= src; // [R5]
      end
    end
  endgenerate

  // Unit attention per initiator; a new set beats a same-cycle clear
  wire [7:0] attn_set = commit ? ~(8'h01 << cmd_id) : 8'h00; // [R11]
  wire [7:0] attn_clr = wr_req ? (8'h01 << pwdata[2:0]) : 8'h00;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      attn <= 8'h00;
      req_id <= 3'h0;
      req_check <= 1'b0;
    end
    else
    begin
      attn <= (attn & ~attn_clr) | attn_set; // [R11]
      if (wr_req)
      begin
        req_id <= pwdata[2:0];
        req_check <= attn[pwdata[2:0]]; // [R11]
      end
    end
  end

  // APB read mux and error decode
  wire [2:0] widx = paddr[4:2];
  wire [4:0] bidx = {widx, 2'b00};
  wire cfg_hit = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'b00) && (widx < `MSP_CFG_WORDS);
  always @*
  begin
    next_prdata = 32'h00000000;
    next_err = 1'b0;
    if (paddr == `MSP_ADDR_CMD0)
      next_prdata = {cdb[3], cdb[2], cdb[1], cdb[0]};
    else if (paddr == `MSP_ADDR_CMD1)
      next_prdata = {13'h0000, cmd_id, cdb[5], cdb[4]};
    else if (paddr == `MSP_ADDR_CTRL)
      next_prdata = {31'h00000000, state};
    else if (paddr == `MSP_ADDR_DATA)
      next_prdata = {26'h0000000, buf_cnt};
    else if (paddr == `MSP_ADDR_STATUS)
      next_prdata = {8'h00, st_ascq, st_asc, st_key, 1'b0, st_check, st_done, state};
    else if (paddr == `MSP_ADDR_REQ)
      next_prdata = {28'h0000000, req_check, req_id};
    else if (paddr == `MSP_ADDR_ATTN)
      next_prdata = {24'h000000, attn};
    else if (cfg_hit && (paddr[7:5] == `MSP_ADDR_WORK_BASE))
      next_prdata = {work_mem[bidx + 5'd3], work_mem[bidx + 5'd2], work_mem[bidx + 5'd1], work_mem[bidx]};
    else if (cfg_hit && (paddr[7:5] == `MSP_ADDR_SAVE_BASE))
      next_prdata = {save_mem[bidx + 5'd3], save_mem[bidx + 5'd2], save_mem[bidx + 5'd1], save_mem[bidx]};
    else
      next_err = 1'b1;
  end

  // One access cycle with no wait state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
      pready <= 1'b1;
      pslverr <= next_err;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule // msp_mode_select
`default_nettype wire

// ===== inc/msp_regs.vh
// Purpose: Constants for the mode select parameter interpreter
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Behaviour list follows
// Behaviour
// (R1) Opcode 15h marks a mode parameter write
// (R2) Decode LUN, PF, length, control byte fields; code decodes only PF, save bit and length
// (R3) Initiator always sets page format bit
// (R4) Save bit zero: update working copy only
// (R5) Save bit one: also write nonvolatile copy
// (R6) Length only 0, 8, 12, 24, 28, 32
// (R7) Length zero completes good, no data
// (R8) Header 4, address page 20, others 4
// (R9) Address page comes before small pages
// (R10) One configuration shared by all initiators
// (R11) Other initiators get unit attention 6h/2Ah/01h; code keeps a per-initiator flag read as req_check, no sense codes
// (R12) Validate everything before any commit
// (R13) Reload saved values on resets
// (R14) Header bytes are all zero
// (R15) Bad length or PF gives illegal request
`ifndef MSP_REGS_VH
`define MSP_REGS_VH

`define MSP_ADDR_CMD0 12'h000
`define MSP_ADDR_CMD1 12'h004
`define MSP_ADDR_CTRL 12'h008
`define MSP_ADDR_DATA 12'h00C
`define MSP_ADDR_STATUS 12'h010
`define MSP_ADDR_REQ 12'h014
`define MSP_ADDR_ATTN 12'h018
`define MSP_ADDR_WORK_BASE 3'b001
`define MSP_ADDR_SAVE_BASE 3'b010
`define MSP_CFG_WORDS 3'h7

`define MSP_CTRL_START 0
`define MSP_CTRL_BUS_RESET 1
`define MSP_CTRL_DEV_RESET 2
`define MSP_CTRL_FLUSH 3

`define MSP_OPCODE 8'h15
`define MSP_PF_BIT 4
`define MSP_SP_BIT 0
`define MSP_LEN_0 8'h00
`define MSP_LEN_8 8'h08
`define MSP_LEN_12 8'h0C
`define MSP_LEN_24 8'h18
`define MSP_LEN_28 8'h1C
`define MSP_LEN_32 8'h20
`define MSP_HDR_LEN 6'h04
`define MSP_ADDR_PAGE_LEN 6'h14
`define MSP_SMALL_LEN 6'h04
`define MSP_BUF_DEPTH 32
`define MSP_CFG_BYTES 28

`define MSP_ADDR_PAGE_CODE 6'h1D
`define MSP_ADDR_PAGE_PLEN 8'h12
`define MSP_PAR_PAGE_CODE 6'h21
`define MSP_BAUD_PAGE_CODE 6'h22
`define MSP_SMALL_PAGE_PLEN 8'h02
`define MSP_NUM_MT 16'h0001
`define MSP_NUM_STORAGE 16'h000A
`define MSP_NUM_IE 16'h0000
`define MSP_FIRST_IE 16'h0000
`define MSP_NUM_DT 16'h0001
`define MSP_DFLT_MT_ADDR 16'h000B
`define MSP_DFLT_ST_ADDR 16'h0001
`define MSP_DFLT_DT_ADDR 16'h0000
`define MSP_DFLT_SMALL_VAL 16'h0000

`define MSP_KEY_GOOD 4'h0
`define MSP_KEY_ILLEGAL 4'h5
`define MSP_KEY_ATTN 4'h6
`define MSP_ASC_NONE 8'h00
`define MSP_ASC_BAD_OPCODE 8'h20
`define MSP_ASC_CDB_FIELD 8'h24
`define MSP_ASC_LIST_LEN 8'h1A
`define MSP_ASC_PARAM_FIELD 8'h26
`define MSP_ASC_PARAM_CHANGED 8'h2A
`define MSP_ASCQ_NONE 8'h00
`define MSP_ASCQ_PARAM_CHANGED 8'h01

`endif

// ===== core/msp_cdb_check.v
// Purpose: Decode the six-byte command block of a mode select
// Assumes: Bytes are stable while the result is used
// Notes: Purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "msp_regs.vh"
module msp_cdb_check
(
  input wire [7:0] cdb_op,
  input wire [7:0] cdb_flags,
  input wire [7:0] cdb_len,
  output wire op_ok,
  output wire pf_ok,
  output wire len_ok,
  output wire len_zero,
  output wire save_req,
  output wire has_addr,
  output reg [1:0] n_small
);
  assign op_ok = (cdb_op == `MSP_OPCODE); // [R1]
  assign pf_ok = cdb_flags[`MSP_PF_BIT]; // [R2] [R15]
  assign save_req = cdb_flags[`MSP_SP_BIT];
  assign len_zero = (cdb_len == `MSP_LEN_0); // [R7]
  assign len_ok = (cdb_len == `MSP_LEN_0) || (cdb_len == `MSP_LEN_8) || (cdb_len == `MSP_LEN_12) ||
                  (cdb_len == `MSP_LEN_24) || (cdb_len == `MSP_LEN_28) || (cdb_len == `MSP_LEN_32); // [R6]
  assign has_addr = (cdb_len == `MSP_LEN_24) || (cdb_len == `MSP_LEN_28) || (cdb_len == `MSP_LEN_32); // [R8]

  always @*
  begin
    case (cdb_len)
      `MSP_LEN_8: n_small = 2'd1;
      `MSP_LEN_28: n_small = 2'd1;
      `MSP_LEN_12: n_small = 2'd2;
      `MSP_LEN_32: n_small = 2'd2;
      default: n_small = 2'd0;
    endcase
  end
endmodule // msp_cdb_check
`default_nettype wire

// ===== dv/msp_init_model.sv
// Purpose: APB initiator model issuing mode select commands
// Assumes: Slave may insert wait states
// Notes: Used through its tasks
`timescale 1ns/1ns
`default_nettype none
module msp_init_model
(
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  function automatic logic [7:0] lb(input logic [7:0] len, hb, mt, input int i);
    int j;
    j = i - 4;
    if (i < 4)
      return hb;
    if (len >= 8'h18 && j < 20)
      case (j)
        0: return 8'h1D;
        1: return 8'h12;
        3: return mt;
        5, 7, 17: return 8'h01;
        9: return 8'h0A;
        default: return 8'h00;
      endcase
    if (len >= 8'h18)
      j = j - 20;
    case (j % 4)
      0: return (j < 4) ? 8'h21 : 8'h22;
      1: return 8'h02;
      3: return mt;
      default: return 8'h00;
    endcase
  endfunction

  task automatic send(input logic [7:0] op, input logic [2:0] id, input logic sp, pf,
    input logic [7:0] len, nb, hb, mt);
    logic [31:0] q;
    logic e;
    xfer(1'b1, 12'h008, 32'h8, q, e);
    xfer(1'b1, 12'h000, {16'h0, 3'b000, pf, 3'b000, sp, op}, q, e);
    xfer(1'b1, 12'h004, {13'h0, id, 8'h00, len}, q, e);
    for (int i = 0; i < nb; i++)
      xfer(1'b1, 12'h00C, {24'h0, lb(len, hb, mt, i)}, q, e);
    xfer(1'b1, 12'h008, 32'h1, q, e);
  endtask
endmodule // msp_init_model
`default_nettype wire

// ===== dv/msp_mode_select_checker.sv
// Purpose: Port checks for the mode select block
// Assumes: Master goes from setup to access at once
// Notes: Bound to the top module
`timescale 1ns/1ns
`default_nettype none
module msp_mode_select_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  wire st = acc && !pwrite && paddr == 12'h010;

  AST_RDY_NEXT: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  AST_RDY_PULSE: assert property (pready |=> !pready) else $error("ready too long");
  AST_RDY_CAUSE: assert property ($rose(pready) |-> $past(psel && !penable)) else $error("stray ready");
  AST_WR_ZERO: assert property (acc && pwrite |-> prdata == 32'h0) else $error("write data out");
  AST_HOLE_ERR: assert property (acc && paddr == 12'h01C |-> pslverr) else $error("hole not refused");
  AST_STAT_OK: assert property (st |-> !pslverr) else $error("status refused");
  AST_CHK_KEY: assert property (st && prdata[2] |-> prdata[7:4] == 4'h5 && prdata[23:16] == 8'h00)
    else $error("bad sense key");
  AST_CHK_ASC: assert property (st && prdata[2] |-> prdata[15:8] inside {8'h20, 8'h24, 8'h1A, 8'h26})
    else $error("bad sense code");
  AST_GOOD_CLEAN: assert property (st && prdata[1] && !prdata[2] |-> prdata[23:4] == 20'h0)
    else $error("sense on good end");
  AST_DONE_IDLE: assert property (st && prdata[1] |-> !prdata[0]) else $error("done while busy");

  cover property (st && prdata[2]);
  cover property (st && prdata[1] && !prdata[2]);
  cover property (acc && pslverr);
endmodule // msp_mode_select_checker

bind msp_mode_select msp_mode_select_checker chk_u
(
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr)
);
`default_nettype wire

// ===== dv/tb.sv
// Purpose: Self-checking bench for the mode select block
// Assumes: Initiator model drives the APB side
// Notes: Rows hold op,sp,pf,len,count,hdr,addr,key,asc,work,saved
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct packed {
    logic [7:0] op;
    logic [3:0] sp, pf;
    logic [7:0] len, nb, hb, mt;
    logic [3:0] key;
    logic [7:0] asc, wmt, smt;
  } msp_row_t;
  msp_row_t rows [0:10] = '{
    76'h15_0_1_18_18_00_0C_0_00_0C_0B, 76'h15_1_1_1C_1C_00_0D_0_00_0D_0D,
    76'h15_0_1_00_00_00_0E_0_00_0D_0D, 76'h15_0_0_18_18_00_0E_5_24_0D_0D,
    76'h15_0_1_10_10_00_0E_5_24_0D_0D, 76'h15_0_1_18_14_00_0E_5_1A_0D_0D,
    76'h15_1_1_18_18_01_0E_5_26_0D_0D, 76'h15_0_1_08_08_00_0E_0_00_0D_0D,
    76'h15_0_1_0C_0C_00_0E_0_00_0D_0D, 76'h15_0_1_20_20_00_0E_0_00_0E_0D,
    76'h16_0_1_18_18_00_0F_5_20_0E_0D};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int fails, check_count;

  msp_mode_select dut_u(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  msp_init_model mdl_u(.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task automatic ck(input string n, input logic [31:0] x, g);
    check_count++;
    if (g !== x)
    begin
      fails++;
      $display("ERROR %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic rd(input logic [11:0] a);
    mdl_u.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    mdl_u.xfer(1'b1, a, d, q, e);
  endtask
  task automatic fin;
    q = 32'h0;
    for (int k = 0; k < 8 && q[1] !== 1'b1; k++)
      rd(12'h010);
  endtask
  task automatic cfg(input logic [7:0] w, s);
    rd(12'h020);
    ck("work", {w, 24'h00121D}, q);
    rd(12'h040);
    ck("saved", {s, 24'h00121D}, q);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    final_report;
  end

  initial
  begin
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[r])
    begin
      mdl_u.send(rows[r].op, 3'd1, rows[r].sp[0], rows[r].pf[0], rows[r].len, rows[r].nb, rows[r].hb, rows[r].mt);
      fin;
      ck("status", {16'h0, rows[r].asc, rows[r].key, 1'b0, rows[r].key != 4'h0, 2'b10}, q);
      cfg(rows[r].wmt, rows[r].smt);
    end
    rd(12'h034);
    ck("work parity", 32'h0E000221, q);
    rd(12'h038);
    ck("work baud", 32'h0E000222, q);
    rd(12'h054);
    ck("saved parity", 32'h0D000221, q);
    rd(12'h058);
    ck("saved baud", 32'h00000222, q);
    rd(12'h000);
    ck("cmd0", 32'h00001016, q);
    rd(12'h004);
    ck("cmd1", 32'h00010018, q);
    rd(12'h018);
    ck("attn", 32'hFD, q);
    wr(12'h014, 32'h2);
    rd(12'h014);
    ck("req other", 32'hA, q);
    wr(12'h014, 32'h2);
    rd(12'h014);
    ck("req again", 32'h2, q);
    wr(12'h014, 32'h1);
    rd(12'h014);
    ck("req issuer", 32'h1, q);
    mdl_u.send(8'h15, 3'd3, 1'b0, 1'b1, 8'h18, 8'h18, 8'h00, 8'h0F);
    fin;
    cfg(8'h0F, 8'h0D);
    rd(12'h018);
    ck("attn 3", 32'hFF, q);
    wr(12'h008, 32'h2);
    cfg(8'h0D, 8'h0D);
    mdl_u.send(8'h15, 3'd3, 1'b0, 1'b1, 8'h18, 8'h18, 8'h00, 8'h0C);
    fin;
    wr(12'h008, 32'h4);
    cfg(8'h0D, 8'h0D);
    mdl_u.xfer(1'b0, 12'h01C, 32'h0, q, e);
    ck("hole", 32'h1, {31'h0, e});
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cfg(8'h0B, 8'h0B);
    rd(12'h018);
    ck("attn rst", 32'h0, q);
    rd(12'h010);
    ck("status rst", 32'h0, q);
    final_report;
  end
endmodule // tb
`default_nettype wire
